/* common/csp_pkg.sv */
package csp_pkg;

  // Bus address of this port; the value after power-up
  localparam logic [6:0] DEV_ADDR = 7'h47;

  // Bit counter positions within one nine-clock byte slot
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Windows that hold real configuration bytes
  localparam logic [7:0] LO_FIRST = 8'h0a;
  localparam logic [7:0] LO_LAST = 8'h17;
  localparam logic [7:0] HI_FIRST = 8'h40;
  localparam logic [7:0] HI_LAST = 8'h57;
  localparam int LO_COUNT = 14;
  localparam int REG_COUNT = 38;

  // Register offsets
  localparam logic [7:0] REG_SEP_SUPPLY = 8'h41;
  localparam logic [7:0] REG_COMMON_SUPPLY = 8'h43;
  localparam logic [7:0] REG_OUT_C = 8'h48;
  localparam logic [7:0] REG_OUT_D_SEL = 8'h50;
  localparam logic [7:0] REG_OUT_E_SEL = 8'h53;
  localparam logic [7:0] REG_OUT_E = 8'h54;
  localparam logic [7:0] REG_OUT_F_SEL = 8'h55;
  localparam logic [7:0] REG_OUT_F = 8'h56;
  localparam logic [7:0] REG_OUT_G = 8'h57;

  // Values after reset
  localparam logic [7:0] RST_SEP_SUPPLY = 8'hbf;
  localparam logic [7:0] RST_COMMON_SUPPLY = 8'ha0;
  localparam logic [7:0] RST_OUT_C = 8'h80;
  localparam logic [7:0] RST_OUT_D_SEL = 8'h8e;
  localparam logic [7:0] RST_OUT_E_SEL = 8'h3e;
  localparam logic [7:0] RST_OUT_E = 8'h80;
  localparam logic [7:0] RST_OUT_F_SEL = 8'h0c;
  localparam logic [7:0] RST_OUT_F = 8'he0;
  localparam logic [7:0] RST_OUT_G = 8'h98;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

  // Drive strength field positions (low bit of each two-bit field)
  localparam int DS_C_LSB = 6;
  localparam int DS_D_LSB = 0;
  localparam int DS_E_LSB = 6;
  localparam int DS_F_LSB = 4;
  localparam int DS_G_LSB = 6;

  typedef enum logic [2:0] {ST_ADDR, ST_REG, ST_WDATA, ST_RDATA, ST_IGNORE} csp_link_state_type;

endpackage

/* hw/csp_serial_port.sv */
`timescale 1ns/100ps
// How it works
// - Port answers only bus address 47h, a seven-bit value.
// - Read and write transfers work at serial clocks up to 400 kbit/s.
// - Write is start, address, direction, ack, register byte, ack, data and acks, stop.
// - Start is data falling with clock high; address byte always follows it.
// - Stop is data rising with clock high; it ends the frame.
// - Data sampled while clock high; data line changes only while clock low.
// - On writes the port pulls data low in the ninth clock of each byte.
// - Further written bytes are stored, acknowledged, and the address advances by one.
// - Read starts like a write but with direction bit set to one.
// - Pointer holds last accessed address plus one; bare read returns that byte.
// - Master ends a read by withholding acknowledge and stopping; port releases data.
// - Register byte then repeated start loads pointer, stores nothing, read follows.
// - Each master acknowledge advances the pointer and sends the next byte.
// - Reads outside the configuration windows complete and return meaningless bytes.
// - Pointer wraps from ffh to 00h.
// - Separate supply byte at 41h resets to bfh; 7fh selects 2.5 V.
// - Common supply byte at 43h resets to a0h; 90h selects 2.5 V.
// - New frequency takes effect byte by byte, each byte as soon as it is written.
// - Every drive strength field resets to 10 and accepts any value.
// - Bits 7:6 of 48h are the drive strength of output C.
// - Bits 1:0 of 53h are the drive strength of output D.
module csp_serial_port (
  // System clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // Two-wire link
  input wire logic SERIAL_CLOCK,
  input wire logic SERIAL_DATA_PIN_IN,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE,
  // Configuration seen by the synthesizer
  output logic [7:0] SEPARATE_SUPPLY_SETTING,
  output logic [7:0] COMMON_SUPPLY_SETTING,
  output logic [1:0] DRIVE_STRENGTH_C,
  output logic [1:0] DRIVE_STRENGTH_D,
  output logic [1:0] DRIVE_STRENGTH_E,
  output logic [1:0] DRIVE_STRENGTH_F,
  output logic [1:0] DRIVE_STRENGTH_G
);

  function automatic logic [6:0] map_addr(input logic [7:0] a);
    logic [6:0] r;
    r = 7'h00;
    if (a >= csp_pkg::LO_FIRST && a <= csp_pkg::LO_LAST)
    begin
      r = {1'b1, 6'(a - csp_pkg::LO_FIRST)};
    end
    else if (a >= csp_pkg::HI_FIRST && a <= csp_pkg::HI_LAST)
    begin
      r = {1'b1, 6'(a - csp_pkg::HI_FIRST + 8'(csp_pkg::LO_COUNT))};
    end
    return r;
  endfunction

  function automatic logic [7:0] reg_default(input logic [7:0] a);
    logic [7:0] r;
    r = csp_pkg::RST_OTHER;
    case (a)
      csp_pkg::REG_SEP_SUPPLY: r = csp_pkg::RST_SEP_SUPPLY;
      csp_pkg::REG_COMMON_SUPPLY: r = csp_pkg::RST_COMMON_SUPPLY;
      csp_pkg::REG_OUT_C: r = csp_pkg::RST_OUT_C;
      csp_pkg::REG_OUT_D_SEL: r = csp_pkg::RST_OUT_D_SEL;
      csp_pkg::REG_OUT_E_SEL: r = csp_pkg::RST_OUT_E_SEL;
      csp_pkg::REG_OUT_E: r = csp_pkg::RST_OUT_E;
      csp_pkg::REG_OUT_F_SEL: r = csp_pkg::RST_OUT_F_SEL;
      csp_pkg::REG_OUT_F: r = csp_pkg::RST_OUT_F;
      csp_pkg::REG_OUT_G: r = csp_pkg::RST_OUT_G;
      default: r = csp_pkg::RST_OTHER;
    endcase
    return r;
  endfunction

  // System side
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic start_det, stop_det;
  logic link_clr, link_rst;
  logic [2:0] tgl_m, tgl_s, tgl_p;
  logic set_evt, wr_evt, inc_evt;
  logic [7:0] ptr;
  logic [7:0] rd_byte;
  logic [6:0] ptr_map;
  logic [7:0] mem [0:csp_pkg::REG_COUNT-1];

  // Link side
  csp_pkg::csp_link_state_type state;
  logic [3:0] bitcnt;
  logic [7:0] shift;
  logic ack_pend;
  logic [7:0] tx;
  logic [2:0] evt_tgl;
  logic [7:0] evt_byte;
  logic [7:0] full_byte;
  logic byte_end, ack_slot, addr_match, ack_now;
  logic do_set, do_wr, do_load, tx_bit;
  logic sda_oe;

  // Pins are sampled through two stages; 25 system clocks per bit at top rate leave ample margin
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_m <= SERIAL_CLOCK;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= SERIAL_DATA_PIN_IN;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign start_det = scl_s && scl_p && sda_p && !sda_s;
  assign stop_det = scl_s && scl_p && !sda_p && sda_s;

  // Frame edges clear the link logic, which has no clock edge of its own there
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      link_clr <= 1'b1;
      link_rst <= 1'b1;
    end
    else
    begin
      link_clr <= start_det || stop_det;
      link_rst <= 1'b0;
    end
  end

  // Toggle events from the link; their byte is held steady for a whole byte slot
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      tgl_m <= 3'h0;
      tgl_s <= 3'h0;
      tgl_p <= 3'h0;
    end
    else
    begin
      tgl_m <= evt_tgl;
      tgl_s <= tgl_m;
      tgl_p <= tgl_s;
    end
  end

  assign set_evt = tgl_s[0] ^ tgl_p[0];
  assign wr_evt = tgl_s[1] ^ tgl_p[1];
  assign inc_evt = tgl_s[2] ^ tgl_p[2];

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      ptr <= csp_pkg::RST_PTR;
    end
    else if (set_evt)
    begin
      ptr <= evt_byte;
    end
    else if (wr_evt || inc_evt)
    begin
      ptr <= ptr + 8'h01;
    end
  end

  assign ptr_map = map_addr(ptr);

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      rd_byte <= csp_pkg::UNMAPPED_BYTE;
    end
    else
    begin
      rd_byte <= ptr_map[6] ? mem[ptr_map[5:0]] : csp_pkg::UNMAPPED_BYTE;
    end
  end

  // Each byte takes effect as written, so a multi-byte setting passes through mixed states
  generate
    for (genvar i = 0; i < csp_pkg::REG_COUNT; i++)
    begin : g_reg
      localparam logic [7:0] ADDR = (i < csp_pkg::LO_COUNT) ? csp_pkg::LO_FIRST + 8'(i)
                                                              : csp_pkg::HI_FIRST + 8'(i - csp_pkg::LO_COUNT);
      always_ff @(posedge CLK_SYS)
      begin
        if (!RST_B)
        begin
          mem[i] <= reg_default(ADDR);
        end
        else if (wr_evt && ptr_map[6] && ptr_map[5:0] == 6'(i))
        begin
          mem[i] <= evt_byte;
        end
      end
    end
  endgenerate

  localparam logic [6:0] IDX_SEP = map_addr(csp_pkg::REG_SEP_SUPPLY);
  localparam logic [6:0] IDX_COMMON = map_addr(csp_pkg::REG_COMMON_SUPPLY);
  localparam logic [6:0] IDX_C = map_addr(csp_pkg::REG_OUT_C);
  localparam logic [6:0] IDX_D = map_addr(csp_pkg::REG_OUT_E_SEL);
  localparam logic [6:0] IDX_E = map_addr(csp_pkg::REG_OUT_E);
  localparam logic [6:0] IDX_F = map_addr(csp_pkg::REG_OUT_F);
  localparam logic [6:0] IDX_G = map_addr(csp_pkg::REG_OUT_G);

  // Top bit of a mapped index is only the valid flag, never part of the array index
  assign SEPARATE_SUPPLY_SETTING = mem[IDX_SEP[5:0]];
  assign COMMON_SUPPLY_SETTING = mem[IDX_COMMON[5:0]];
  assign DRIVE_STRENGTH_C = mem[IDX_C[5:0]][csp_pkg::DS_C_LSB +: 2];
  assign DRIVE_STRENGTH_D = mem[IDX_D[5:0]][csp_pkg::DS_D_LSB +: 2];
  assign DRIVE_STRENGTH_E = mem[IDX_E[5:0]][csp_pkg::DS_E_LSB +: 2];
  assign DRIVE_STRENGTH_F = mem[IDX_F[5:0]][csp_pkg::DS_F_LSB +: 2];
  assign DRIVE_STRENGTH_G = mem[IDX_G[5:0]][csp_pkg::DS_G_LSB +: 2];

  // Link side decode
  always_comb
  begin
    full_byte = {shift[6:0], SERIAL_DATA_PIN_IN};
    byte_end = (bitcnt == csp_pkg::BIT_LAST);
    ack_slot = (bitcnt == csp_pkg::BIT_ACK);
    addr_match = (full_byte[7:1] == csp_pkg::DEV_ADDR);
    ack_now = (state == csp_pkg::ST_ADDR && addr_match) || state == csp_pkg::ST_REG
              || state == csp_pkg::ST_WDATA;
    do_set = byte_end && state == csp_pkg::ST_REG;
    do_wr = byte_end && state == csp_pkg::ST_WDATA;
    do_load = ack_slot && state == csp_pkg::ST_RDATA && (ack_pend || !SERIAL_DATA_PIN_IN);
    tx_bit = tx[3'(csp_pkg::BIT_LAST[2:0] - bitcnt[2:0])];
  end

  // Bits are taken on the rising clock, while the line is stable
  always_ff @(posedge SERIAL_CLOCK or posedge link_clr)
  begin
    if (link_clr)
    begin
      state <= csp_pkg::ST_ADDR;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      ack_pend <= 1'b0;
      tx <= 8'h00;
    end
    else
    begin
      bitcnt <= ack_slot ? 4'h0 : bitcnt + 4'h1;
      shift <= full_byte;
      ack_pend <= byte_end && ack_now;
      if (do_load)
      begin
        tx <= rd_byte;
      end
      if (byte_end)
      begin
        case (state)
          csp_pkg::ST_ADDR:
          begin
            if (!addr_match)
            begin
              state <= csp_pkg::ST_IGNORE;
            end
            else if (full_byte[0])
            begin
              state <= csp_pkg::ST_RDATA;
            end
            else
            begin
              state <= csp_pkg::ST_REG;
            end
          end
          csp_pkg::ST_REG: state <= csp_pkg::ST_WDATA;
          default: state <= state;
        endcase
      end
      else if (ack_slot && state == csp_pkg::ST_RDATA && !ack_pend && SERIAL_DATA_PIN_IN)
      begin
        state <= csp_pkg::ST_IGNORE;
      end
    end
  end

  // Events keep their own reset so a frame edge cannot fake a toggle
  always_ff @(posedge SERIAL_CLOCK or posedge link_rst)
  begin
    if (link_rst)
    begin
      evt_tgl <= 3'h0;
      evt_byte <= 8'h00;
    end
    else
    begin
      if (do_set || do_wr)
      begin
        evt_byte <= full_byte;
      end
      evt_tgl <= evt_tgl ^ {do_load, do_wr, do_set};
    end
  end

  // The line is moved only on the falling clock; a stop clears it at once
  always_ff @(negedge SERIAL_CLOCK or posedge link_clr)
  begin
    if (link_clr)
    begin
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_oe <= ack_pend || (state == csp_pkg::ST_RDATA && !ack_pend && bitcnt <= csp_pkg::BIT_LAST
                && !tx_bit);
    end
  end

  assign SERIAL_DATA_PIN_OE = sda_oe;
  assign SERIAL_DATA_PIN_OUT = 1'b0;

  sequence s_addr_byte(logic [6:0] a);
    state == csp_pkg::ST_ADDR && byte_end && full_byte[7:1] == a;
  endsequence

  sequence s_read_nack;
    state == csp_pkg::ST_RDATA && ack_slot && !ack_pend && SERIAL_DATA_PIN_IN;
  endsequence

  a_addr_ack: assert property (@(posedge SERIAL_CLOCK) disable iff (link_clr)
    s_addr_byte(csp_pkg::DEV_ADDR) |=> ack_pend)
    else $error("own address byte not acknowledged");

  a_foreign_quiet: assert property (@(posedge SERIAL_CLOCK) disable iff (link_clr)
    (state == csp_pkg::ST_ADDR && byte_end && !addr_match) |=> state == csp_pkg::ST_IGNORE && !ack_pend [*2])
    else $error("foreign address byte not ignored");

  a_ack_drive: assert property (@(negedge SERIAL_CLOCK) disable iff (link_clr)
    ack_pend |=> sda_oe)
    else $error("acknowledge not driven low");

  a_read_end: assert property (@(posedge SERIAL_CLOCK) disable iff (link_clr)
    s_read_nack |=> state == csp_pkg::ST_IGNORE ##1 !sda_oe)
    else $error("read not ended after missing acknowledge");

  a_tx_load: assert property (@(posedge SERIAL_CLOCK) disable iff (link_clr)
    do_load |=> tx == $past(rd_byte) && bitcnt == 4'h0)
    else $error("read byte not loaded");

  a_ptr_wrap: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (inc_evt && !set_evt && ptr == 8'hff) |=> ptr == 8'h00)
    else $error("pointer did not wrap");

  a_write_step: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (wr_evt && !set_evt) |=> ptr == $past(ptr) + 8'h01)
    else $error("pointer did not advance after write");

  a_ptr_load: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    set_evt |=> ptr == $past(evt_byte))
    else $error("pointer not loaded from register byte");

  a_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    !ptr_map[6] |=> rd_byte == csp_pkg::UNMAPPED_BYTE)
    else $error("unmapped read not zero");

  a_stop_release: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    stop_det |=> ##1 !SERIAL_DATA_PIN_OE)
    else $error("data line held after stop");

endmodule

/* verification/csp_bus_master.sv */
`timescale 1ns/100ps
module csp_bus_master #(
  parameter int QUARTER_NS = 700
) (
  // Link pins
  output logic scl,
  output logic sda_low,
  // Resolved data wire
  input wire logic sda_in
);
  // Clock stands high between frames; data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Quarter of 2.8 us keeps the clock under the link limit
  task automatic put_bit(input logic b);
    sda_low = ~b;
    #QUARTER_NS scl = 1'b1;
    #(2 * QUARTER_NS) scl = 1'b0;
    #QUARTER_NS;
  endtask

  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS b = sda_in;
    #QUARTER_NS scl = 1'b0;
    #QUARTER_NS;
  endtask

  task automatic start();
    sda_low = 1'b0;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS sda_low = 1'b1;
    #QUARTER_NS scl = 1'b0;
    #QUARTER_NS;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS sda_low = 1'b0;
    #QUARTER_NS;
  endtask

  // Whole byte, MSB first, then the slave's answer
  task automatic send(input logic [7:0] b, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i]);
    get_bit(nak);
    ack = (nak === 1'b0);
  endtask

  task automatic recv(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(~mack);
  endtask
endmodule

/* verification/tb_clock_synth_serial_config_port.sv */
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  tests_run++; \
  if ((got) !== (exp)) \
  begin \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
    miscompares++; \
  end
module tb_clock_synth_serial_config_port;
  logic clk_sys;
  logic rst_b;
  logic scl;
  logic m_low;
  logic dut_oe;
  logic dut_out;
  logic sda;
  logic [7:0] sep;
  logic [7:0] com;
  logic [1:0] ds_c, ds_d, ds_e, ds_f, ds_g;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  // Open-drain wire with pull-up
  assign sda = !(m_low || dut_oe);

  csp_serial_port i_csp_serial_port (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .SERIAL_CLOCK(scl), .SERIAL_DATA_PIN_IN(sda),
    .SERIAL_DATA_PIN_OUT(dut_out), .SERIAL_DATA_PIN_OE(dut_oe),
    .SEPARATE_SUPPLY_SETTING(sep), .COMMON_SUPPLY_SETTING(com), .DRIVE_STRENGTH_C(ds_c),
    .DRIVE_STRENGTH_D(ds_d), .DRIVE_STRENGTH_E(ds_e), .DRIVE_STRENGTH_F(ds_f), .DRIVE_STRENGTH_G(ds_g)
  );

  csp_bus_master i_csp_bus_master (.scl(scl), .sda_low(m_low), .sda_in(sda));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic end_of_test();
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Generous ceiling; the sequence needs about 19000 cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d[3], input int n);
    logic ack;
    i_csp_bus_master.start();
    i_csp_bus_master.send({csp_pkg::DEV_ADDR, 1'b0}, ack);
    `CHK("addr ack", 1'b1, ack)
    i_csp_bus_master.send(a, ack);
    `CHK("reg ack", 1'b1, ack)
    for (int i = 0; i < n; i++)
    begin
      i_csp_bus_master.send(d[i], ack);
      `CHK("data ack", 1'b1, ack)
    end
    i_csp_bus_master.stop();
  endtask

  task automatic rd(input logic rnd, input logic [7:0] a, input logic [7:0] e[3], input int n);
    logic ack;
    logic [7:0] got;
    i_csp_bus_master.start();
    if (rnd)
    begin
      i_csp_bus_master.send({csp_pkg::DEV_ADDR, 1'b0}, ack);
      i_csp_bus_master.send(a, ack);
      `CHK("ptr ack", 1'b1, ack)
      i_csp_bus_master.start();
    end
    i_csp_bus_master.send({csp_pkg::DEV_ADDR, 1'b1}, ack);
    `CHK("read ack", 1'b1, ack)
    for (int i = 0; i < n; i++)
    begin
      i_csp_bus_master.recv(i < n - 1, got);
      `CHK("read byte", e[i], got)
    end
    i_csp_bus_master.stop();
    `CHK("released", 1'b0, dut_oe)
  endtask

  task automatic t_defaults();
    `CHK("sep supply", 8'hbf, sep)
    `CHK("common supply", 8'ha0, com)
    `CHK("drives", 10'h2aa, {ds_c, ds_d, ds_e, ds_f, ds_g})
    `CHK("drive level", 1'b0, dut_out)
  endtask

  task automatic t_burst();
    wr(8'h41, '{8'h7f, 8'h55, 8'h90}, 3);
    `CHK("sep supply", 8'h7f, sep)
    `CHK("common supply", 8'h90, com)
    rd(1'b1, 8'h41, '{8'h7f, 8'h55, 8'h90}, 3);
  endtask

  // Pointer left at last read plus one
  task automatic t_current();
    rd(1'b1, 8'h42, '{8'h55, 8'h00, 8'h00}, 1);
    rd(1'b0, 8'h00, '{8'h90, 8'h00, 8'h00}, 1);
  endtask

  task automatic t_foreign();
    logic ack;
    i_csp_bus_master.start();
    i_csp_bus_master.send(8'h90, ack);
    `CHK("foreign ack", 1'b0, ack)
    i_csp_bus_master.send(8'h41, ack);
    i_csp_bus_master.send(8'h11, ack);
    `CHK("foreign data ack", 1'b0, ack)
    i_csp_bus_master.stop();
    `CHK("sep kept", 8'h7f, sep)
  endtask

  // Shared bytes composed whole, written out of order
  task automatic t_drive();
    wr(8'h57, '{8'h58, 8'h00, 8'h00}, 1);
    wr(8'h48, '{8'hc9, 8'h00, 8'h00}, 1);
    wr(8'h53, '{8'h8f, 8'h40, 8'h0c}, 3);
    wr(8'h56, '{8'hd0, 8'h00, 8'h00}, 1);
    `CHK("drive f", 2'b01, ds_f)
    `CHK("drive c", 2'b11, ds_c)
    `CHK("drive d", 2'b11, ds_d)
    `CHK("drive e", 2'b01, ds_e)
    `CHK("drive g", 2'b01, ds_g)
  endtask

  task automatic t_wrap();
    wr(8'h0a, '{8'h5a, 8'h00, 8'h00}, 1);
    rd(1'b1, 8'hff, '{8'h00, 8'h00, 8'h00}, 3);
    // Only a marked byte past the wrap tells a wrapped pointer from a stuck one
    for (int k = 0; k < 2; k++)
      rd(1'b0, 8'h00, '{8'h00, 8'h00, 8'h00}, 3);
    rd(1'b0, 8'h00, '{8'h00, 8'h00, 8'h5a}, 3);
    rd(1'b1, 8'h20, '{8'h00, 8'h00, 8'h00}, 1);
  endtask

  task automatic t_reset();
    @(posedge clk_sys);
    #1 rst_b = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_defaults();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    rst_b = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_defaults();
    t_burst();
    t_current();
    t_foreign();
    t_drive();
    t_wrap();
    t_reset();
    t_burst();
    end_of_test();
  end
endmodule
